// ===== rtl/io_channel_handshake.sv
`timescale 1ns/1ns
`default_nettype none
module io_channel_handshake #(
    parameter int RESP_MINORS = io_channel_pkg::RESP_MINORS_DEF,
    parameter int GAP_MAJORS = io_channel_pkg::GAP_MAJORS_DEF,
    parameter bit HAS_ERROR_RETURN = 1'b1,
    parameter bit ODD_PARITY = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire io_channel_pkg::op_t cmd_op,
    input wire logic [io_channel_pkg::WORD_W-1:0] cmd_word,
    output logic cmd_ack,
    output logic cmd_reject,
    input wire logic out_valid,
    input wire logic [io_channel_pkg::WORD_W-1:0] out_data,
    output logic out_ready,
    output logic in_valid,
    output logic [io_channel_pkg::WORD_W-1:0] in_data,
    input wire logic in_ready,
    input wire logic error_clear,
    output logic active_flag,
    output logic full_flag,
    output logic error_flag,
    output logic [io_channel_pkg::WORD_W-1:0] channel_word,
    input wire logic [io_channel_pkg::WORD_W-1:0] ch_in_data,
    input wire logic ch_in_parity,
    input wire logic ch_in_full,
    input wire logic ch_in_empty,
    input wire logic ch_in_inactive,
    input wire logic ch_in_active,
    input wire logic ch_in_error,
    output logic [io_channel_pkg::WORD_W-1:0] ch_out_data,
    output logic ch_out_parity,
    output logic ch_out_function,
    output logic ch_out_full,
    output logic ch_out_empty,
    output logic ch_out_active,
    output logic ch_out_inactive
);
    import io_channel_pkg::*;

    localparam int SW = WORD_W + 1 + C_N;
    localparam logic [CNT_W-1:0] RESP_LOAD = CNT_W'(RESP_MINORS * MINOR_CYC - 1);
    localparam logic [CNT_W-1:0] STEP_LOAD = CNT_W'(STEP_CYC - 1);
    localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYC - 1);
    localparam logic [MAJ_W-1:0] MAJ_LAST = MAJ_W'(MAJOR_CYC - 1);
    localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(GAP_MAJORS - 1);

    logic [SW-1:0] sync1_q, sync2_q;
    logic [C_N-1:0] ctl_prev_q, edge_s;
    logic [WORD_W-1:0] rx_data, ob_data;
    logic rx_par;
    state_t state_q;
    logic active_q, full_q, own_q, error_q, inact_seen_q, resp_pend_q;
    logic cmd_ack_q, cmd_reject_q;
    logic [WORD_W-1:0] chan_q, out_word_q;
    logic out_par_q;
    logic [MAJ_W-1:0] maj_cnt_q;
    logic [GAP_W-1:0] gap_q;
    logic [CNT_W-1:0] resp_q, pulse_cnt_q;
    logic [P_N-1:0] pulse_q, pulse_start;
    logic pulse_idle, maj_tick, func_ok, deact_ok, cmd_take;
    logic issue_func, issue_act, issue_deact, ext_act, ext_inact;
    logic in_cap, out_ack, load_out, ans_in, resp_done, func_done, gap_done;
    logic ib_ready, ob_valid, err_set;

    // every channel input passes two flops before use
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            ctl_prev_q <= '0;
        end else begin
            sync1_q <= {ch_in_error, ch_in_active, ch_in_inactive, ch_in_empty, ch_in_full,
                        ch_in_parity, ch_in_data};
            sync2_q <= sync1_q;
            ctl_prev_q <= sync2_q[SW-1 -: C_N];
        end
    end

    assign edge_s = sync2_q[SW-1 -: C_N] & ~ctl_prev_q;
    assign rx_par = sync2_q[WORD_W];
    assign rx_data = sync2_q[WORD_W-1:0];

    assign pulse_idle = (pulse_q == '0);
    assign maj_tick = (maj_cnt_q == MAJ_LAST);
    assign func_ok = (state_q == S_IDLE) && !active_q && pulse_idle;
    assign deact_ok = (state_q == S_ACT) && !full_q && pulse_idle && !edge_s[C_INACT];

    always_comb begin
        cmd_take = 1'b0;
        if (cmd_valid) begin
            unique case (cmd_op)
                OP_FUNCTION: cmd_take = func_ok;
                OP_ACTIVATE: cmd_take = func_ok;
                OP_DEACTIVATE: cmd_take = deact_ok;
                default: cmd_take = 1'b0;
            endcase
        end
    end

    assign issue_func = cmd_take && (cmd_op == OP_FUNCTION);
    assign issue_act = cmd_take && (cmd_op == OP_ACTIVATE);
    assign issue_deact = cmd_take && (cmd_op == OP_DEACTIVATE);
    assign ext_act = (state_q == S_IDLE) && !active_q && edge_s[C_ACT] && !cmd_take;
    assign ext_inact = (state_q == S_ACT) && edge_s[C_INACT];
    assign in_cap = (state_q == S_ACT) && active_q && !full_q && edge_s[C_FULL]
                    && !ext_inact && !issue_deact;
    assign out_ack = (state_q == S_ACT) && full_q && own_q && edge_s[C_EMPTY] && !ext_inact;
    assign resp_done = (resp_q == '0);
    assign load_out = (state_q == S_ACT) && active_q && !full_q && !resp_pend_q && ob_valid
                      && pulse_idle && !issue_deact && !ext_inact && !edge_s[C_FULL];
    assign ans_in = (state_q == S_ACT) && full_q && !own_q && resp_pend_q && resp_done
                    && ib_ready && pulse_idle && !ext_inact;
    assign func_done = (state_q == S_FUNC) && maj_tick
                       && (inact_seen_q || edge_s[C_INACT]);
    assign gap_done = (state_q == S_GAP) && maj_tick && (gap_q == GAP_LAST);
    assign pulse_start = {issue_deact, issue_act, ans_in, load_out, issue_func};
    assign err_set = (in_cap && (rx_par != par_of(rx_data, ODD_PARITY)))
                     || (HAS_ERROR_RETURN && active_q && edge_s[C_ERR]);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (issue_func) begin
                        state_q <= S_FUNC;
                    end else if (issue_act || ext_act) begin
                        state_q <= S_ACT;
                    end
                end
                S_FUNC: begin
                    if (func_done) begin
                        state_q <= S_GAP;
                    end
                end
                S_GAP: begin
                    if (gap_done) begin
                        state_q <= S_IDLE;
                    end
                end
                S_ACT: begin
                    if (issue_deact || ext_inact) begin
                        state_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
        end else if (issue_func || issue_act || ext_act) begin
            active_q <= 1'b1;
        end else if (func_done || issue_deact || ext_inact) begin
            active_q <= 1'b0;
        end
    end

    // full is only ever raised together with or under active
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            full_q <= 1'b0;
            own_q <= 1'b0;
            chan_q <= '0;
        end else if (issue_func || load_out) begin
            full_q <= 1'b1;
            own_q <= 1'b1;
            chan_q <= issue_func ? cmd_word : ob_data;
        end else if (in_cap) begin
            full_q <= 1'b1;
            own_q <= 1'b0;
            chan_q <= rx_data;
        end else if (func_done || out_ack || ans_in || issue_deact || ext_inact) begin
            full_q <= 1'b0;
            chan_q <= '0;
        end
    end

    // a new error wins over a clear in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            error_q <= 1'b0;
        end else if (err_set) begin
            error_q <= 1'b1;
        end else if (error_clear) begin
            error_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            inact_seen_q <= 1'b0;
            maj_cnt_q <= '0;
            gap_q <= '0;
        end else begin
            if (issue_func) begin
                inact_seen_q <= 1'b0;
            end else if (state_q == S_FUNC && edge_s[C_INACT]) begin
                inact_seen_q <= 1'b1;
            end
            if (issue_func || maj_tick) begin
                maj_cnt_q <= '0;
            end else begin
                maj_cnt_q <= maj_cnt_q + MAJ_W'(1);
            end
            if (func_done) begin
                gap_q <= '0;
            end else if (state_q == S_GAP && maj_tick) begin
                gap_q <= gap_q + GAP_W'(1);
            end
        end
    end

    // answer delay: minor cycles first, then whole steps while stalled
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            resp_q <= '0;
            resp_pend_q <= 1'b0;
        end else if (in_cap || out_ack) begin
            resp_q <= RESP_LOAD;
            resp_pend_q <= 1'b1;
        end else if (issue_deact || ext_inact || ans_in) begin
            resp_pend_q <= 1'b0;
        end else if (resp_pend_q && !resp_done) begin
            resp_q <= resp_q - CNT_W'(1);
        end else if (resp_pend_q && !full_q) begin
            resp_pend_q <= 1'b0;
        end else if (resp_pend_q && pulse_idle) begin
            resp_q <= STEP_LOAD;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pulse_q <= '0;
            pulse_cnt_q <= '0;
        end else if (pulse_start != '0) begin
            pulse_q <= pulse_start;
            pulse_cnt_q <= PULSE_LOAD;
        end else if (!pulse_idle) begin
            if (pulse_cnt_q == '0) begin
                pulse_q <= '0;
            end else begin
                pulse_cnt_q <= pulse_cnt_q - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_word_q <= '0;
            out_par_q <= 1'b0;
        end else if (issue_func) begin
            out_word_q <= cmd_word;
            out_par_q <= par_of(cmd_word, ODD_PARITY);
        end else if (load_out) begin
            out_word_q <= ob_data;
            out_par_q <= par_of(ob_data, ODD_PARITY);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_ack_q <= 1'b0;
            cmd_reject_q <= 1'b0;
        end else begin
            cmd_ack_q <= cmd_take;
            cmd_reject_q <= cmd_valid && !cmd_take;
        end
    end

    word_buffer #(.WIDTH(WORD_W)) out_buf (
        .clock(clock),
        .rst_n(rst_n),
        .s_valid(out_valid),
        .s_data(out_data),
        .s_ready(out_ready),
        .m_valid(ob_valid),
        .m_data(ob_data),
        .m_ready(load_out)
    );

    word_buffer #(.WIDTH(WORD_W)) in_buf (
        .clock(clock),
        .rst_n(rst_n),
        .s_valid(ans_in),
        .s_data(chan_q),
        .s_ready(ib_ready),
        .m_valid(in_valid),
        .m_data(in_data),
        .m_ready(in_ready)
    );

    assign cmd_ack = cmd_ack_q;
    assign cmd_reject = cmd_reject_q;
    assign active_flag = active_q;
    assign full_flag = full_q;
    assign error_flag = error_q;
    assign channel_word = chan_q;
    assign ch_out_data = out_word_q;
    assign ch_out_parity = out_par_q;
    assign ch_out_function = pulse_q[P_FUNC];
    assign ch_out_full = pulse_q[P_FULL];
    assign ch_out_empty = pulse_q[P_EMPTY];
    assign ch_out_active = pulse_q[P_ACT];
    assign ch_out_inactive = pulse_q[P_INACT];

    // helper counters for the checks below
    logic [CNT_W-1:0] since_q;
    logic [11:0] gap_cyc_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            since_q <= '0;
            gap_cyc_q <= '0;
        end else begin
            if (in_cap || out_ack) begin
                since_q <= '0;
            end else if (since_q != '1) begin
                since_q <= since_q + CNT_W'(1);
            end
            gap_cyc_q <= (state_q == S_GAP) ? gap_cyc_q + 12'h001 : 12'h000;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_func_issue;
        issue_func;
    endsequence
    sequence s_func_out;
        ch_out_function && full_q && active_q && !ch_out_active && !ch_out_full;
    endsequence
    sequence s_inactive_pulse;
        (!active_q && ch_out_inactive) [*7] ##1 !ch_out_inactive;
    endsequence

    a_full_needs_active: assert property (full_q |-> active_q)
        else $error("full flag set while channel inactive");
    a_func_flags: assert property (s_func_issue |=> s_func_out)
        else $error("function issue did not set flags and pulse");
    a_func_quiet: assert property (state_q == S_FUNC |-> !ch_out_active && !ch_out_full)
        else $error("active or full pulse during function");
    a_func_on_major: assert property (
        state_q == S_GAP && $past(state_q) == S_FUNC |-> maj_cnt_q == '0)
        else $error("function acceptance off major boundary");
    a_parity_error: assert property (
        in_cap && rx_par != par_of(rx_data, ODD_PARITY) |=> error_flag)
        else $error("parity failure did not set error flag");
    a_empty_delay: assert property ($rose(ch_out_empty) |-> since_q >= CNT_W'(MINOR_CYC))
        else $error("empty answer sooner than one minor cycle");
    a_gap_length: assert property (
        state_q == S_IDLE && $past(state_q) == S_GAP
        |-> gap_cyc_q == 12'(GAP_MAJORS * MAJOR_CYC))
        else $error("post-function gap not whole major cycles");
    a_deact_pulse: assert property (issue_deact |=> s_inactive_pulse)
        else $error("deactivate did not drop active with inactive pulse");
    a_ext_inactive: assert property (
        ext_inact |=> !active_q && !full_q && state_q == S_IDLE)
        else $error("far inactive did not disconnect");
    a_store_word: assert property (ans_in |=> !full_q && ch_out_empty && channel_word == '0)
        else $error("stored word did not clear full and send empty");
    a_out_full: assert property (
        load_out |=> full_q && ch_out_full && ch_out_data == $past(ob_data))
        else $error("output word not sent with full pulse");
endmodule
`default_nettype wire

// ===== rtl/io_channel_pkg.sv
// Notes on behaviour
// - input parity failure sets channel error flag
// - returned output error sets flag if supported
// - slower answers stretch by whole 100 ns
// - function loads register, sets full, active
// - inactive accepts function, clears flags, register
// - activation sets active and sends active pulse
// - device stores word, clears full, sends empty
// - far inactive ends input, clears active flag
// - device may end input by deactivating early
// - output loads word, sets full, sends full
// - far empty clears register and full flag
// - after last empty, deactivate sends inactive
// - inactive after function recognised on major cycles
// - answer waits one to four minor cycles
// - post-function gap two whole major cycles
// - timing in 500 ns majors, 50 ns minors
// - disconnect allowed after any input empty
// - function or activate only when inactive
// - function sends no active or full pulse
// - full flag never set while inactive
package io_channel_pkg;
    localparam int WORD_W = 12;
    localparam int CLK_NS = 4;
    localparam int MAJOR_NS = 500;
    localparam int MINOR_NS = 50;
    localparam int STEP_NS = 100;
    localparam int PULSE_NS = 25;
    localparam int MAJOR_CYC = MAJOR_NS / CLK_NS;
    localparam int MINOR_CYC = (MINOR_NS + CLK_NS - 1) / CLK_NS;
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int MAJ_W = $clog2(MAJOR_CYC);
    localparam int CNT_W = 8;
    localparam int GAP_W = 4;
    localparam int GAP_MAJORS_DEF = 2;
    localparam int RESP_MINORS_DEF = 1;
    // control pin indices after synchronisation
    localparam int C_FULL = 0;
    localparam int C_EMPTY = 1;
    localparam int C_INACT = 2;
    localparam int C_ACT = 3;
    localparam int C_ERR = 4;
    localparam int C_N = 5;
    // outgoing pulse indices
    localparam int P_FUNC = 0;
    localparam int P_FULL = 1;
    localparam int P_EMPTY = 2;
    localparam int P_ACT = 3;
    localparam int P_INACT = 4;
    localparam int P_N = 5;

    typedef enum logic [1:0] {
        OP_FUNCTION = 2'h0,
        OP_ACTIVATE = 2'h1,
        OP_DEACTIVATE = 2'h2
    } op_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_FUNC = 2'h1,
        S_GAP = 2'h2,
        S_ACT = 2'h3
    } state_t;

    function automatic logic par_of(input logic [WORD_W-1:0] w, input logic odd);
        return (^w) ^ odd;
    endfunction
endpackage

// ===== rtl/word_buffer.sv
`timescale 1ns/1ns
`default_nettype none
module word_buffer #(
    parameter int WIDTH = 12
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic s_valid,
    input wire logic [WIDTH-1:0] s_data,
    output logic s_ready,
    output logic m_valid,
    output logic [WIDTH-1:0] m_data,
    input wire logic m_ready
);
    logic [WIDTH-1:0] head_q, tail_q;
    logic [1:0] count_q, count_d;
    logic push, pop;

    assign push = s_valid && s_ready;
    assign pop = m_valid && m_ready;
    assign m_data = head_q;

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 2'h1;
        end else if (pop && !push) begin
            count_d = count_q - 2'h1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 2'h0;
            s_ready <= 1'b1;
            m_valid <= 1'b0;
        end else begin
            count_q <= count_d;
            s_ready <= (count_d != 2'h2);
            m_valid <= (count_d != 2'h0);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            head_q <= '0;
            tail_q <= '0;
        end else begin
            if (pop) begin
                head_q <= (count_q == 2'h2) ? tail_q : s_data;
            end else if (push && count_q == 2'h0) begin
                head_q <= s_data;
            end
            if (push && ((count_q == 2'h1 && !pop) || count_q == 2'h2)) begin
                tail_q <= s_data;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/far_controller.sv
`timescale 1ns/1ns
`default_nettype none
module far_controller (
    input wire logic clock,
    input wire logic [io_channel_pkg::WORD_W-1:0] ch_out_data,
    input wire logic ch_out_parity,
    input wire logic ch_out_function,
    input wire logic ch_out_full,
    input wire logic ch_out_empty,
    output logic [io_channel_pkg::WORD_W-1:0] ch_in_data,
    output logic ch_in_parity,
    output logic [io_channel_pkg::C_N-1:0] pin_q
);
    import io_channel_pkg::*;
    int steps = 0;
    int waited = 0;
    logic [WORD_W:0] got[$];
    logic [WORD_W-1:0] funcs[$];
    initial begin
        ch_in_data = '0;
        ch_in_parity = 1'h0;
        pin_q = '0;
    end
    task automatic pulse(input int i, input int d);
        repeat (d) @(posedge clock);
        #1 pin_q[i] = 1'h1;
        repeat (PULSE_CYC) @(posedge clock);
        #1 pin_q[i] = 1'h0;
    endtask
    always @(posedge ch_out_function) begin
        #1 funcs.push_back(ch_out_data);
        pulse(C_INACT, 10 + steps * STEP_CYC);
    end
    always @(posedge ch_out_full) begin
        #1 got.push_back({ch_out_parity, ch_out_data});
        pulse(C_EMPTY, 10 + steps * STEP_CYC);
    end
    task automatic send(input logic [WORD_W-1:0] w, input logic bad);
        @(posedge clock);
        #1 ch_in_data = w;
        ch_in_parity = ~^w ^ bad;
        pulse(C_FULL, 1);
        waited = PULSE_CYC;
        while (ch_out_empty !== 1'h1) begin
            @(posedge clock);
            #1;
            waited++;
        end
        // released lines show garbage, not the old word
        ch_in_data = ~w;
        ch_in_parity = ~ch_in_parity;
    endtask
endmodule
`default_nettype wire

// ===== tb/io_channel_handshake_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module io_channel_handshake_tb_top;
    import io_channel_pkg::*;
    typedef struct {logic [WORD_W-1:0] w; logic bad;} row_t;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic cmd_valid = 1'h0;
    op_t cmd_op = OP_FUNCTION;
    logic [WORD_W-1:0] cmd_word = '0;
    logic out_valid = 1'h0;
    logic [WORD_W-1:0] out_data = '0;
    logic in_ready = 1'h1;
    logic error_clear = 1'h0;
    logic cmd_ack, cmd_reject, out_ready, in_valid, active_flag, full_flag, error_flag;
    logic [WORD_W-1:0] in_data, channel_word, ch_in_data, ch_out_data, d;
    logic ch_in_parity, ch_out_parity, ch_out_function, ch_out_full, ch_out_empty;
    logic ch_out_active, ch_out_inactive;
    logic [C_N-1:0] pins;
    int mismatches = 0;
    int comparisons = 0;
    int n_act = 0;
    int n_inact = 0;
    int k;
    row_t rows [4] = '{'{12'h000, 1'h0}, '{12'hFFF, 1'h0}, '{12'hA5A, 1'h1}, '{12'h001, 1'h0}};
    logic [WORD_W-1:0] ow [3] = '{12'hFFF, 12'h000, 12'h5A3};

    always #2 clock = ~clock;
    always @(posedge ch_out_active) n_act++;
    always @(posedge ch_out_inactive) n_inact++;

    io_channel_handshake DUT (
        .clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_word(cmd_word), .cmd_ack(cmd_ack), .cmd_reject(cmd_reject),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
        .error_clear(error_clear), .active_flag(active_flag), .full_flag(full_flag),
        .error_flag(error_flag), .channel_word(channel_word), .ch_in_data(ch_in_data),
        .ch_in_parity(ch_in_parity), .ch_in_full(pins[C_FULL]),
        .ch_in_empty(pins[C_EMPTY]), .ch_in_inactive(pins[C_INACT]),
        .ch_in_active(pins[C_ACT]), .ch_in_error(pins[C_ERR]), .ch_out_data(ch_out_data),
        .ch_out_parity(ch_out_parity), .ch_out_function(ch_out_function),
        .ch_out_full(ch_out_full), .ch_out_empty(ch_out_empty),
        .ch_out_active(ch_out_active), .ch_out_inactive(ch_out_inactive)
    );
    far_controller u_far (
        .clock(clock), .ch_out_data(ch_out_data), .ch_out_parity(ch_out_parity),
        .ch_out_function(ch_out_function), .ch_out_full(ch_out_full),
        .ch_out_empty(ch_out_empty), .ch_in_data(ch_in_data),
        .ch_in_parity(ch_in_parity), .pin_q(pins)
    );

    task automatic check(input string n, input logic [WORD_W-1:0] s, input logic [WORD_W-1:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic cmd(input op_t op, input logic [WORD_W-1:0] w, input logic ok);
        cmd_op = op;
        cmd_word = w;
        cmd_valid = 1'h1;
        step(1);
        cmd_valid = 1'h0;
        check("ack", cmd_ack, ok);
        check("reject", cmd_reject, !ok);
        step(1);
    endtask
    task automatic wait_in(output logic [WORD_W-1:0] v);
        for (int n = 0; in_valid !== 1'h1 && n < 300; n++) step(1);
        check("in_valid", in_valid, 1'h1);
        v = in_data;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        step(20000);
        mismatches++;
        give_verdict();
    end

    initial begin
        step(16);
        rst_n = 1'h1;
        check("rst", {active_flag, full_flag, error_flag, out_ready}, 12'h001);
        cmd(OP_FUNCTION, 12'h7A5, 1'h1);
        check("creg", channel_word, 12'h7A5);
        check("flags", {active_flag, full_flag, ch_out_function}, 12'h007);
        check("odata", ch_out_data, 12'h7A5);
        check("opar", ch_out_parity, ~^12'h7A5);
        check("nopulse", ch_out_full | ch_out_active, 1'h0);
        for (k = 0; active_flag === 1'h1 && k < 1000; k++) step(1);
        check("turn", k >= 123 && k <= 126, 1'h1);
        check("clear", channel_word | full_flag, 12'h000);
        check("func", u_far.funcs[0], 12'h7A5);
        cmd(OP_ACTIVATE, 12'h000, 1'h0);
        step(200);
        cmd(OP_ACTIVATE, 12'h000, 1'h0);
        step(60);
        cmd(OP_ACTIVATE, 12'h000, 1'h1);
        check("act", {active_flag, n_act[0]}, 12'h003);
        $display("test function done");
        foreach (rows[i]) begin
            fork
                u_far.send(rows[i].w, rows[i].bad);
                wait_in(d);
            join
            check("in_data", d, rows[i].w);
            check("err", error_flag, rows[i].bad);
            check("resp", u_far.waited inside {[MINOR_CYC:4*MINOR_CYC+PULSE_CYC]}, 1'h1);
            error_clear = 1'h1;
            step(1);
            error_clear = 1'h0;
        end
        $display("test input rows done");
        in_ready = 1'h0;
        fork
            for (int i = 0; i < 3; i++) u_far.send(12'h100 + i, 1'h0);
            begin
                step(300);
                check("held", {full_flag, in_valid}, 12'h003);
                in_ready = 1'h1;
                for (int i = 0; i < 3; i++) begin
                    wait_in(d);
                    check("buf", d, 12'h100 + i);
                    step(1);
                end
            end
        join
        step(20);
        cmd(OP_DEACTIVATE, 12'h000, 1'h1);
        check("deact", {active_flag, ch_out_inactive}, 12'h001);
        cmd(OP_DEACTIVATE, 12'h000, 1'h0);
        cmd(op_t'(2'h3), 12'h000, 1'h0);
        $display("test input stall done");
        step(20);
        cmd(OP_ACTIVATE, 12'h000, 1'h1);
        u_far.steps = 1;
        foreach (ow[i]) begin
            out_data = ow[i];
            out_valid = 1'h1;
            while (out_ready !== 1'h1) step(1);
            step(1);
        end
        out_valid = 1'h0;
        for (k = 0; u_far.got.size() < 3 && k < 2000; k++) step(1);
        step(60);
        foreach (ow[i]) begin
            check("oword", u_far.got[i][WORD_W-1:0], ow[i]);
            check("opar", u_far.got[i][WORD_W], ~^ow[i]);
        end
        check("empty", channel_word | full_flag, 12'h000);
        cmd(OP_DEACTIVATE, 12'h000, 1'h1);
        check("shut", {active_flag, n_inact[1:0]}, 12'h002);
        $display("test output done");
        step(20);
        u_far.pulse(C_ACT, 0);
        step(4);
        check("ext", active_flag, 1'h1);
        u_far.pulse(C_ERR, 0);
        step(4);
        check("oerr", error_flag, 1'h1);
        u_far.pulse(C_INACT, 0);
        step(4);
        check("end", {active_flag, full_flag}, 12'h000);
        $display("test far side done");
        give_verdict();
    end
endmodule
`default_nettype wire
